// *** core/swf_status_bank.sv ***
// Status registers, start condition flags and halt gating
//
// Operation
// - Carry or borrow from the arithmetic unit is stored in status one bit 3.
// - Zero flag at status one bit 2 is high exactly when accumulator is zero.
// - Reading status one copies it to accumulator and data memory.
// - Writing status one from memory loads only carry; other bits read only.
// - Reading status two copies it out; status two is never written from memory.
// - Port D change releasing halt sets bit 3; port setup clears it.
// - Port C change releasing halt sets bit 1; port setup clears it.
// - Status two bit 2 is the OR of the five other wake flags.
// - Halt entry is refused while any start condition flag is set.
// - Flag set/clear with operand 2h sets/clears backup mode bit 0.
// - External pin request with enable sets status three bit 0; clears with either.
// - Timer one request with enable sets status three bit 1; clears with either.
// - Prescaler request with enable sets status three bit 3; clears with either.
// - Status three bit 2 shows the live prescaler 15th stage.
// - Reading status three copies it out; all bits read only.
// - Timer two request with enable sets extended bit 1; clears with either.
// - Gated mode 3 converter finish with enable sets extended bit 3.
// - Reading extended status three copies it out; bit 2 unused, all read only.
// - Slow instruction clears fast clock select; fast instruction sets it.
// - Status four shows whether the watchdog runs, read only.
// - Reading status four copies it out; bit 3 reserved, all read only.
// - Counter overflow sets status four bit 2; counter init clears it.
`timescale 1ns/100ps
`include "swf_defs.svh"

module swf_status_bank (
  input  wire logic                sys_clk,          // System clock, 100 MHz
  input  wire logic                nrst,             // Asynchronous reset, active low
  input  wire swf_pkg::swf_instr_t instr,            // Instruction from the core
  input  wire logic                alu_carry_we,     // Arithmetic result updates carry
  input  wire logic                alu_carry,        // Carry or borrow of that result
  input  wire logic [3:0]          acc_value,        // Current accumulator contents
  input  wire logic                port_c_evt,       // Selected port C change released halt
  input  wire logic                port_d_evt,       // Selected port D change released halt
  input  wire logic [5:0]          wake_request,     // Wake requests 1 to 6
  input  wire logic [5:0]          wake_enable,      // Wake enables 1 to 6
  input  wire logic [3:0]          key_inputs,       // Key input levels
  input  wire logic                lcd_mode,         // High: LCD mode, keys active low
  input  wire logic                rfc_gated_mode3,  // Converter in mode 3 gated by gate pin
  input  wire logic                prescaler_stage15,// Prescaler 15th stage output
  input  wire logic                freq_counter_ovf, // Converter 16-bit counter overflow
  input  wire logic                watchdog_running, // Watchdog timer is running
  output logic                     key_activity,     // Any key active, raises request 5
  output swf_pkg::swf_rd_t         status_rd_q,      // Read data to accumulator and memory
  output logic                     halt_enter,       // Halt instruction accepted
  output logic                     halt_blocked,     // Some start condition flag is set
  output logic                     fast_clock_selected, // Base clock from fast oscillator
  output logic                     backup_mode,      // Backup mode flag
  output logic                     carry_out         // Carry flag to the arithmetic unit
);

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode

  logic op_read_s1;
  logic op_write_s1;
  logic op_read_s2;
  logic op_read_s3;
  logic op_read_s3x;
  logic op_read_s4;
  logic op_set_backup;
  logic op_clr_backup;
  logic op_port_setup;
  logic op_slow;
  logic op_fast;
  logic op_freq_init;
  logic op_halt;
  logic backup_operand;

  // Every decode needs the valid bit; the backup operand must match in full
  assign backup_operand = (instr.operand == `SWF_BACKUP_OPERAND);
  assign op_read_s1     = instr.valid & (instr.op == swf_pkg::SWF_OP_READ_S1);
  assign op_write_s1    = instr.valid & (instr.op == swf_pkg::SWF_OP_WRITE_S1);
  assign op_read_s2     = instr.valid & (instr.op == swf_pkg::SWF_OP_READ_S2);
  assign op_read_s3     = instr.valid & (instr.op == swf_pkg::SWF_OP_READ_S3);
  assign op_read_s3x    = instr.valid & (instr.op == swf_pkg::SWF_OP_READ_S3X);
  assign op_read_s4     = instr.valid & (instr.op == swf_pkg::SWF_OP_READ_S4);
  assign op_set_backup  = instr.valid & (instr.op == swf_pkg::SWF_OP_SET_FLAG)
                          & backup_operand;
  assign op_clr_backup  = instr.valid & (instr.op == swf_pkg::SWF_OP_CLEAR_FLAG)
                          & backup_operand;
  assign op_port_setup  = instr.valid & (instr.op == swf_pkg::SWF_OP_PORT_SETUP);
  assign op_slow        = instr.valid & (instr.op == swf_pkg::SWF_OP_SLOW_CLK);
  assign op_fast        = instr.valid & (instr.op == swf_pkg::SWF_OP_FAST_CLK);
  assign op_freq_init   = instr.valid & (instr.op == swf_pkg::SWF_OP_FREQ_INIT);
  assign op_halt        = instr.valid & (instr.op == swf_pkg::SWF_OP_HALT);

  ////////////////////////////////////////////////////////////////////////////
  // Status one: carry and zero

  logic carry_q;
  logic carry_d;
  logic zero_flag;

  // Arithmetic result wins if it lands with a memory load in one cycle
  assign carry_d = alu_carry_we ? alu_carry :
                   op_write_s1  ? instr.ram_data[`SWF_S1_CARRY_BIT] :
                   carry_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      carry_q <= `SWF_FLAG_RESET;
    end else begin
      carry_q <= carry_d;
    end
  end

  assign zero_flag = (acc_value == 4'h0);
  assign carry_out = carry_q;

  ////////////////////////////////////////////////////////////////////////////
  // Status two: port flags and backup mode

  logic port_c_flag;
  logic port_d_flag;
  logic backup_flag;
  logic summary_flag;

  // A change that meets the port setup in one cycle keeps its flag set
  swf_sticky_flag u_port_c (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .set_now (port_c_evt),
    .clr_now (op_port_setup),
    .flag_q  (port_c_flag)
  );

  swf_sticky_flag u_port_d (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .set_now (port_d_evt),
    .clr_now (op_port_setup),
    .flag_q  (port_d_flag)
  );

  swf_sticky_flag u_backup (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .set_now (op_set_backup),
    .clr_now (op_clr_backup),
    .flag_q  (backup_flag)
  );

  assign backup_mode = backup_flag;

  ////////////////////////////////////////////////////////////////////////////
  // Start condition flags from wake requests and enables

  logic [5:0] wake_flag;
  logic [5:0] wake_qual;

  // Key polarity flips with display mode
  assign key_activity = lcd_mode ? ~(&key_inputs) : (|key_inputs);

  // Only the converter finish needs a qualifier beyond its enable
  assign wake_qual = {rfc_gated_mode3, 5'b1_1111};

  genvar gi;
  generate
    for (gi = 0; gi < `SWF_WAKE_COUNT; gi = gi + 1) begin : g_wake
      swf_wake_cell u_cell (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .req_lvl (wake_request[gi]),
        .en_lvl  (wake_enable[gi]),
        .qual_ok (wake_qual[gi]),
        .flag_q  (wake_flag[gi])
      );
    end
  endgenerate

  logic [5:0] summary_src;
  logic       any_wake;

  // The key flag holds off halt but has no place in the summary bit
  always_comb begin
    summary_src               = wake_flag;
    summary_src[`SWF_IDX_KEY] = 1'b0;
  end

  assign summary_flag = |summary_src;
  assign any_wake     = |wake_flag;

  ////////////////////////////////////////////////////////////////////////////
  // Converter overflow and clock selection

  logic freq_ovf_flag;
  logic fast_clk_q;
  logic fast_clk_d;

  swf_sticky_flag u_freq_ovf (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .set_now (freq_counter_ovf),
    .clr_now (op_freq_init),
    .flag_q  (freq_ovf_flag)
  );

  assign fast_clk_d = op_fast ? 1'b1 : (op_slow ? 1'b0 : fast_clk_q);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fast_clk_q <= `SWF_FAST_CLK_RESET;
    end else begin
      fast_clk_q <= fast_clk_d;
    end
  end

  assign fast_clock_selected = fast_clk_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register images

  logic [3:0] s1_image;
  logic [3:0] s2_image;
  logic [3:0] s3_image;
  logic [3:0] s3x_image;
  logic [3:0] s4_image;

  // Bits 1 and 0 of status one carry no flag and read zero
  always_comb begin
    s1_image = 4'h0;
    s1_image[`SWF_S1_CARRY_BIT] = carry_q;
    s1_image[`SWF_S1_ZERO_BIT]  = zero_flag;
  end

  always_comb begin
    s2_image = 4'h0;
    s2_image[`SWF_S2_PORT_D_BIT]  = port_d_flag;
    s2_image[`SWF_S2_SUMMARY_BIT] = summary_flag;
    s2_image[`SWF_S2_PORT_C_BIT]  = port_c_flag;
    s2_image[`SWF_S2_BACKUP_BIT]  = backup_flag;
  end

  always_comb begin
    s3_image = 4'h0;
    s3_image[`SWF_S3_PRESC_OVF_BIT] = wake_flag[`SWF_IDX_PRESC];
    s3_image[`SWF_S3_STAGE15_BIT]   = prescaler_stage15;
    s3_image[`SWF_S3_TIMER1_BIT]    = wake_flag[`SWF_IDX_TIMER1];
    s3_image[`SWF_S3_EXT_PIN_BIT]   = wake_flag[`SWF_IDX_EXT_PIN];
  end

  // Bit 2 of the extended register has no flag and stays zero
  always_comb begin
    s3x_image = 4'h0;
    s3x_image[`SWF_S3X_RFC_BIT]    = wake_flag[`SWF_IDX_RFC];
    s3x_image[`SWF_S3X_TIMER2_BIT] = wake_flag[`SWF_IDX_TIMER2];
    s3x_image[`SWF_S3X_KEY_BIT]    = wake_flag[`SWF_IDX_KEY];
  end

  // Bit 3 of status four is reserved and reads zero
  always_comb begin
    s4_image = 4'h0;
    s4_image[`SWF_S4_FREQ_OVF_BIT] = freq_ovf_flag;
    s4_image[`SWF_S4_WDOG_BIT]     = watchdog_running;
    s4_image[`SWF_S4_FAST_CLK_BIT] = fast_clk_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path to accumulator and data memory

  logic       rd_any;
  logic [3:0] rd_sel;
  logic [3:0] rd_data_q;
  logic       rd_valid_q;

  // Valid is a one-cycle pulse; the data holds until the next read
  assign rd_any = op_read_s1 | op_read_s2 | op_read_s3 | op_read_s3x | op_read_s4;

  assign rd_sel = op_read_s1  ? s1_image  :
                  op_read_s2  ? s2_image  :
                  op_read_s3  ? s3_image  :
                  op_read_s3x ? s3x_image :
                  op_read_s4  ? s4_image  :
                  4'h0;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= `SWF_NIBBLE_RESET;
    end else begin
      rd_valid_q <= rd_any;
      rd_data_q  <= rd_any ? rd_sel : rd_data_q;
    end
  end

  assign status_rd_q.valid = rd_valid_q;
  assign status_rd_q.data  = rd_data_q;

  ////////////////////////////////////////////////////////////////////////////
  // Halt gating

  // Any pending start condition keeps the core out of halt, key flag included
  // A refused halt leaves every flag as it was
  assign halt_blocked = port_c_flag | port_d_flag | any_wake;
  assign halt_enter   = op_halt & ~halt_blocked;

endmodule : swf_status_bank

// *** core/swf_defs.svh ***
// Bit positions, operands and reset values of the status and wake flag bank
`ifndef SWF_DEFS_SVH
`define SWF_DEFS_SVH

// First status register: carry and zero
`define SWF_S1_CARRY_BIT      2'd3
`define SWF_S1_ZERO_BIT       2'd2

// Second status register: port and summary wake flags, backup mode
`define SWF_S2_PORT_D_BIT     2'd3
`define SWF_S2_SUMMARY_BIT    2'd2
`define SWF_S2_PORT_C_BIT     2'd1
`define SWF_S2_BACKUP_BIT     2'd0

// Third status register: external pin, timer one, prescaler
`define SWF_S3_PRESC_OVF_BIT  2'd3
`define SWF_S3_STAGE15_BIT    2'd2
`define SWF_S3_TIMER1_BIT     2'd1
`define SWF_S3_EXT_PIN_BIT    2'd0

// Extended third status register: converter, timer two, keys
`define SWF_S3X_RFC_BIT       2'd3
`define SWF_S3X_TIMER2_BIT    2'd1
`define SWF_S3X_KEY_BIT       2'd0

// Fourth status register: counter overflow, watchdog, clock select
`define SWF_S4_FREQ_OVF_BIT   2'd2
`define SWF_S4_WDOG_BIT       2'd1
`define SWF_S4_FAST_CLK_BIT   2'd0

// Wake request / enable index (request n sits at index n-1)
`define SWF_WAKE_COUNT        6
`define SWF_IDX_TIMER1        3'd0
`define SWF_IDX_EXT_PIN       3'd1
`define SWF_IDX_PRESC         3'd2
`define SWF_IDX_TIMER2        3'd3
`define SWF_IDX_KEY           3'd4
`define SWF_IDX_RFC           3'd5

// Operand of the flag set / clear instructions that selects backup mode
`define SWF_BACKUP_OPERAND    8'h02

// Reset values
`define SWF_FLAG_RESET        1'b0
`define SWF_FAST_CLK_RESET    1'b0
`define SWF_NIBBLE_RESET      4'h0

`endif

// *** core/swf_pkg.sv ***
// Types shared by the status and wake flag bank
package swf_pkg;

  typedef enum logic [3:0] {
    SWF_OP_NOP        = 4'b0000,
    SWF_OP_READ_S1    = 4'b0001,
    SWF_OP_WRITE_S1   = 4'b0010,
    SWF_OP_READ_S2    = 4'b0011,
    SWF_OP_READ_S3    = 4'b0100,
    SWF_OP_READ_S3X   = 4'b0101,
    SWF_OP_READ_S4    = 4'b0110,
    SWF_OP_SET_FLAG   = 4'b0111,
    SWF_OP_CLEAR_FLAG = 4'b1000,
    SWF_OP_PORT_SETUP = 4'b1001,
    SWF_OP_SLOW_CLK   = 4'b1010,
    SWF_OP_FAST_CLK   = 4'b1011,
    SWF_OP_FREQ_INIT  = 4'b1100,
    SWF_OP_HALT       = 4'b1101
  } swf_op_t;

  typedef struct packed {
    logic       valid;
    swf_op_t    op;
    logic [7:0] operand;
    logic [3:0] ram_data;
  } swf_instr_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] data;
  } swf_rd_t;

endpackage : swf_pkg

// *** core/swf_sticky_flag.sv ***
// Sticky flag with synchronous set and clear, set taking priority
`timescale 1ns/100ps
`include "swf_defs.svh"

module swf_sticky_flag (
  input  wire logic sys_clk,  // System clock
  input  wire logic nrst,     // Asynchronous reset, active low
  input  wire logic set_now,  // Set event
  input  wire logic clr_now,  // Clear event
  output logic      flag_q    // Flag state
);

  logic flag_d;

  assign flag_d = set_now ? 1'b1 : (clr_now ? 1'b0 : flag_q);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      flag_q <= `SWF_FLAG_RESET;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule : swf_sticky_flag

// *** core/swf_wake_cell.sv ***
// Start condition flag driven by one wake request and its enable
`timescale 1ns/100ps
`include "swf_defs.svh"

module swf_wake_cell (
  input  wire logic sys_clk,   // System clock
  input  wire logic nrst,      // Asynchronous reset, active low
  input  wire logic req_lvl,   // Wake request level
  input  wire logic en_lvl,    // Wake enable level
  input  wire logic qual_ok,   // Extra qualifier for the set
  output logic      flag_q     // Start condition flag
);

  logic req_prev_q;
  logic req_rise;
  logic set_evt;
  logic clr_evt;

  // Only a request that rises while the enable already stands counts
  assign req_rise = req_lvl & ~req_prev_q;
  assign set_evt  = req_rise & en_lvl & qual_ok;
  assign clr_evt  = ~req_lvl | ~en_lvl;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      req_prev_q <= 1'b0;
    end else begin
      req_prev_q <= req_lvl;
    end
  end

  swf_sticky_flag u_flag (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .set_now (set_evt),
    .clr_now (clr_evt),
    .flag_q  (flag_q)
  );

endmodule : swf_wake_cell

// *** sim/swf_status_bank_assertions.sv ***
// Port checker for the status and wake flag bank
`timescale 1ns/100ps
module swf_status_bank_assertions (
  input wire logic                sys_clk,             // Clock
  input wire logic                nrst,                // Reset, active low
  input wire swf_pkg::swf_instr_t instr,               // Instruction
  input wire logic                alu_carry_we,        // Carry load
  input wire logic                alu_carry,           // Carry value
  input wire logic [3:0]          acc_value,           // Accumulator
  input wire logic                port_c_evt,          // Port C event
  input wire logic [3:0]          key_inputs,          // Keys
  input wire logic                lcd_mode,            // Key polarity
  input wire logic                prescaler_stage15,   // Stage 15
  input wire logic                watchdog_running,    // Watchdog
  input wire logic                key_activity,        // Key activity
  input wire swf_pkg::swf_rd_t    status_rd_q,         // Read data
  input wire logic                halt_enter,          // Halt accepted
  input wire logic                halt_blocked,        // Halt blocked
  input wire logic                fast_clock_selected, // Clock select
  input wire logic                backup_mode,         // Backup flag
  input wire logic                carry_out            // Carry flag
);
  wire logic rd1 = instr.valid && instr.op == swf_pkg::SWF_OP_READ_S1;
  wire logic rd3 = instr.valid && instr.op == swf_pkg::SWF_OP_READ_S3;
  wire logic rd3x = instr.valid && instr.op == swf_pkg::SWF_OP_READ_S3X;
  wire logic rd4 = instr.valid && instr.op == swf_pkg::SWF_OP_READ_S4;
  wire logic rd2 = instr.valid && instr.op == swf_pkg::SWF_OP_READ_S2;
  wire logic rdany = rd1 || rd2 || rd3 || rd3x || rd4;
  wire logic hlt = instr.valid && instr.op == swf_pkg::SWF_OP_HALT;
  wire logic fst = instr.valid && instr.op == swf_pkg::SWF_OP_FAST_CLK;
  wire logic slw = instr.valid && instr.op == swf_pkg::SWF_OP_SLOW_CLK;
  wire logic pset = instr.valid && instr.op == swf_pkg::SWF_OP_PORT_SETUP;
  wire logic setb = instr.valid && instr.op == swf_pkg::SWF_OP_SET_FLAG && instr.operand == 8'h02;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  a_read_answers: assert property (rdany |=> status_rd_q.valid) else $error("read no answer");
  a_no_stray_read: assert property (!rdany |=> !status_rd_q.valid) else $error("stray read");
  a_zero_follows: assert property (rd1 |=> status_rd_q.data[2:0] == {$past(acc_value) == 4'h0, 2'b00})
    else $error("zero bit wrong");
  a_stage_live: assert property (rd3 |=> status_rd_q.data[2] == $past(prescaler_stage15))
    else $error("stage bit wrong");
  a_s3x_unused: assert property (rd3x |=> !status_rd_q.data[2]) else $error("s3x bit2 set");
  a_s4_image: assert property (rd4 |=> status_rd_q.data[1:0] == {$past(watchdog_running),
    $past(fast_clock_selected)} && !status_rd_q.data[3]) else $error("s4 image wrong");
  a_halt_refused: assert property (halt_blocked |-> !halt_enter) else $error("halt taken");
  a_halt_taken: assert property (hlt && !halt_blocked |-> halt_enter) else $error("halt lost");
  a_clock_select: assert property (fst |=> fast_clock_selected)
    else $error("fast not set");
  a_slow_select: assert property (slw && !fst |=> !fast_clock_selected) else $error("slow");
  a_backup_set: assert property (setb |=> backup_mode) else $error("backup not set");
  a_carry_load: assert property (alu_carry_we |=> carry_out == $past(alu_carry))
    else $error("carry not loaded");
  a_port_blocks: assert property (port_c_evt |=> halt_blocked ##1
    (halt_blocked || $past(pset))) else $error("no block");
  a_key_polarity: assert property (key_activity == (lcd_mode ? key_inputs != 4'hf
    : key_inputs != 4'h0)) else $error("key activity wrong");
  c_halt_refused: cover property (hlt && halt_blocked);
  c_halt_taken: cover property (halt_enter);
  c_backup: cover property (setb);
endmodule : swf_status_bank_assertions

bind swf_status_bank swf_status_bank_assertions u_chk (.sys_clk(sys_clk), .nrst(nrst),
  .instr(instr), .alu_carry_we(alu_carry_we), .alu_carry(alu_carry), .acc_value(acc_value),
  .port_c_evt(port_c_evt), .key_inputs(key_inputs), .lcd_mode(lcd_mode),
  .prescaler_stage15(prescaler_stage15), .watchdog_running(watchdog_running),
  .key_activity(key_activity), .status_rd_q(status_rd_q), .halt_enter(halt_enter),
  .halt_blocked(halt_blocked), .fast_clock_selected(fast_clock_selected),
  .backup_mode(backup_mode), .carry_out(carry_out));

// *** sim/swf_wake_src_model.sv ***
// Wake source model: request and enable flags held on the core side
`timescale 1ns/100ps
module swf_wake_src_model (
  input  wire logic       sys_clk,      // System clock
  input  wire logic       nrst,         // Reset, active low
  input  wire logic [5:0] src_evt,      // Underflow, pin, overflow, finish events
  input  wire logic       key_activity, // Key activity from the bank
  input  wire logic [5:0] clr_req,      // Request clear
  input  wire logic       en_we,        // Enable load
  input  wire logic [5:0] en_val,       // Enable value
  output logic      [5:0] wake_request, // Request levels
  output logic      [5:0] wake_enable   // Enable levels
);
  wire logic [5:0] set_d = src_evt | {1'b0, key_activity, 4'h0};
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wake_request <= 6'h00;
      wake_enable  <= 6'h00;
    end else begin
      wake_request <= (wake_request & ~clr_req) | set_d;
      if (en_we) begin
        wake_enable <= en_val;
      end
    end
  end
endmodule : swf_wake_src_model

// *** sim/swf_status_bank_tb_top.sv ***
// Testbench for the status and wake flag bank
`timescale 1ns/100ps
module swf_status_bank_tb_top;
  logic                sys_clk = 1'b0, nrst = 1'b0;
  swf_pkg::swf_instr_t instr = '0;
  logic                alu_carry_we = 1'b0, alu_carry = 1'b0, port_c_evt = 1'b0;
  logic                port_d_evt = 1'b0, lcd_mode = 1'b0, rfc_gated_mode3 = 1'b0;
  logic                prescaler_stage15 = 1'b0, freq_counter_ovf = 1'b0, en_we = 1'b0;
  logic                watchdog_running = 1'b0, halt_exp = 1'b0;
  logic [3:0]          acc_value = 4'h5, key_inputs = 4'h0;
  logic [5:0]          src_evt = 6'h00, clr_req = 6'h00, en_val = 6'h00;
  logic [5:0]          wake_request, wake_enable;
  logic                key_activity, halt_enter, halt_blocked, fast_clk, backup, carry;
  swf_pkg::swf_rd_t    status_rd_q;
  int                  num_errors = 0, n_tests = 0, cycles = 0;
  logic [3:0]          e3 [6] = '{4'h2, 4'h1, 4'h8, 4'h0, 4'h0, 4'h0};
  logic [3:0]          ex [6] = '{4'h0, 4'h0, 4'h0, 4'h2, 4'h1, 4'h8};

  always #5 sys_clk = ~sys_clk;

  swf_status_bank DUT (.sys_clk(sys_clk), .nrst(nrst), .instr(instr),
    .alu_carry_we(alu_carry_we), .alu_carry(alu_carry), .acc_value(acc_value),
    .port_c_evt(port_c_evt), .port_d_evt(port_d_evt), .wake_request(wake_request),
    .wake_enable(wake_enable), .key_inputs(key_inputs), .lcd_mode(lcd_mode),
    .rfc_gated_mode3(rfc_gated_mode3), .prescaler_stage15(prescaler_stage15),
    .freq_counter_ovf(freq_counter_ovf), .watchdog_running(watchdog_running),
    .key_activity(key_activity), .status_rd_q(status_rd_q), .halt_enter(halt_enter),
    .halt_blocked(halt_blocked), .fast_clock_selected(fast_clk), .backup_mode(backup),
    .carry_out(carry));
  swf_wake_src_model u_src (.sys_clk(sys_clk), .nrst(nrst), .src_evt(src_evt),
    .key_activity(key_activity), .clr_req(clr_req), .en_we(en_we), .en_val(en_val),
    .wake_request(wake_request), .wake_enable(wake_enable));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [4:0] exp, input logic [4:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
      num_errors++;
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick

  task automatic op_run(input swf_pkg::swf_op_t op, input logic [7:0] opd, input logic [3:0] ram);
    @(negedge sys_clk);
    instr = '{1'b1, op, opd, ram};
    #1 if (op == swf_pkg::SWF_OP_HALT) chk({4'h0, halt_exp}, {4'h0, halt_enter});
    @(negedge sys_clk);
    instr.valid = 1'b0;
  endtask : op_run

  task automatic rd(input swf_pkg::swf_op_t op, input logic [3:0] exp);
    op_run(op, 8'h00, 4'h0);
    chk({1'b1, exp}, status_rd_q);
  endtask : rd

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(16);
    nrst = 1'b1;
    rd(swf_pkg::SWF_OP_READ_S1, 4'h0);
    rd(swf_pkg::SWF_OP_READ_S2, 4'h0);
    rd(swf_pkg::SWF_OP_READ_S3X, 4'h0);
    $display("test reset done");
    acc_value = 4'h0;
    alu_carry = 1'b1;
    alu_carry_we = 1'b1;
    tick(1);
    alu_carry_we = 1'b0;
    rd(swf_pkg::SWF_OP_READ_S1, 4'hc);
    op_run(swf_pkg::SWF_OP_WRITE_S1, 8'h00, 4'h3);
    rd(swf_pkg::SWF_OP_READ_S1, 4'h4);
    op_run(swf_pkg::SWF_OP_WRITE_S1, 8'h00, 4'hf);
    acc_value = 4'h9;
    rd(swf_pkg::SWF_OP_READ_S1, 4'h8);
    chk(5'h01, {4'h0, carry});
    $display("test carry done");
    op_run(swf_pkg::SWF_OP_SET_FLAG, 8'h02, 4'h0);
    op_run(swf_pkg::SWF_OP_CLEAR_FLAG, 8'h03, 4'h0);
    rd(swf_pkg::SWF_OP_READ_S2, 4'h1);
    chk(5'h01, {4'h0, backup});
    op_run(swf_pkg::SWF_OP_CLEAR_FLAG, 8'h02, 4'h0);
    rd(swf_pkg::SWF_OP_READ_S2, 4'h0);
    chk(5'h00, {4'h0, backup});
    $display("test backup done");
    port_c_evt = 1'b1;
    tick(1);
    port_c_evt = 1'b0;
    rd(swf_pkg::SWF_OP_READ_S2, 4'h2);
    op_run(swf_pkg::SWF_OP_HALT, 8'h00, 4'h0);
    tick(1);
    instr = '{1'b1, swf_pkg::SWF_OP_PORT_SETUP, 8'h00, 4'h0};
    port_d_evt = 1'b1;
    tick(1);
    instr.valid = 1'b0;
    port_d_evt = 1'b0;
    rd(swf_pkg::SWF_OP_READ_S2, 4'h8);
    op_run(swf_pkg::SWF_OP_PORT_SETUP, 8'h00, 4'h0);
    rd(swf_pkg::SWF_OP_READ_S2, 4'h0);
    halt_exp = 1'b1;
    op_run(swf_pkg::SWF_OP_HALT, 8'h00, 4'h0);
    $display("test ports done");
    lcd_mode = 1'b1;
    key_inputs = 4'hf;
    rfc_gated_mode3 = 1'b1;
    for (int i = 0; i < 6; i++) begin
      en_val = 6'h01 << i;
      en_we = 1'b1;
      tick(1);
      en_we = 1'b0;
      if (i == 4) key_inputs = 4'he;
      else src_evt = 6'h01 << i;
      tick(1);
      src_evt = 6'h00;
      rd(swf_pkg::SWF_OP_READ_S3, e3[i]);
      rd(swf_pkg::SWF_OP_READ_S3X, ex[i]);
      rd(swf_pkg::SWF_OP_READ_S2, (i == 4) ? 4'h0 : 4'h4);
      if (i == 4) chk(5'h01, {4'h0, key_activity});
      chk(5'h01, {4'h0, halt_blocked});
      key_inputs = 4'hf;
      en_we = i[0];
      clr_req = i[0] ? 6'h00 : 6'h01 << i;
      en_val = 6'h00;
      tick(1);
      en_we = 1'b0;
      clr_req = 6'h00;
      tick(1);
      rd(swf_pkg::SWF_OP_READ_S3, 4'h0);
      rd(swf_pkg::SWF_OP_READ_S3X, 4'h0);
      rd(swf_pkg::SWF_OP_READ_S2, 4'h0);
    end
    $display("test wake done");
    prescaler_stage15 = 1'b1;
    rd(swf_pkg::SWF_OP_READ_S3, 4'h4);
    watchdog_running = 1'b1;
    op_run(swf_pkg::SWF_OP_FAST_CLK, 8'h00, 4'h0);
    rd(swf_pkg::SWF_OP_READ_S4, 4'h3);
    chk(5'h01, {4'h0, fast_clk});
    freq_counter_ovf = 1'b1;
    tick(1);
    freq_counter_ovf = 1'b0;
    rd(swf_pkg::SWF_OP_READ_S4, 4'h7);
    op_run(swf_pkg::SWF_OP_FREQ_INIT, 8'h00, 4'h0);
    op_run(swf_pkg::SWF_OP_SLOW_CLK, 8'h00, 4'h0);
    rd(swf_pkg::SWF_OP_READ_S4, 4'h2);
    chk(5'h00, {4'h0, fast_clk});
    $display("test clock done");
    wrap_up();
  end
endmodule : swf_status_bank_tb_top
